// file: hw/deser_config_status_regs.sv
// Configuration and status register bank of the serial-link video deserializer.
// Behaviour
// (RQ1) Sequence kind bit selects checker type.
// (RQ2) Auto clear zeroes fault count after 1us.
// (RQ3) Forward disable bit blocks input forwarding.
// (RQ4) Source code picks sync bits, shifts data.
// (RQ5) Filter disable bits; reset follows width strap.
// (RQ6) Vertical sync replaces control output three.
// (RQ7) Auto pixel count bit enables counting.
// (RQ8) Writable eight-bit fault threshold, reset zero.
// (RQ9) Read-only decode fault counter.
// (RQ10) Read-only sequence mismatch counter.
// (RQ11) Reverse rate bit picks 500k or 1M.
// (RQ12) Audio clock source: pixel or oscillator.
// (RQ13) Zero divider stops audio clock output.
// (RQ14) Rate bit strapped; pin transitions override.
// (RQ15) Drive boost bit selects output strength.
// (RQ16) Inversions, wake disable, interrupt bit level.
// (RQ17) GPIO output bits, read-back input levels.
// (RQ18) Auto mode: info writes raise, reads drop.
module deser_config_status_regs
	import deser_regs_pkg::*;
#(
	parameter int         FILTER_LEN   = FILTER_LEN_DEF,
	parameter logic [7:0] AUDIO_VIDEO_INFO_BYTES_FIRST = AUDIO_VIDEO_INFO_BYTES_FIRST_DEF,
	parameter logic [7:0] AUDIO_VIDEO_INFO_BYTES_LAST  = AUDIO_VIDEO_INFO_BYTES_LAST_DEF
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrEn,
	input  wire logic [7:0]  regWrData,
	input  wire logic        regRdEn,
	output logic      [7:0]  regRdData,
	input  wire logic        gpiPin,
	input  wire logic        gpio1Pin,
	input  wire logic        gpio0Pin,
	input  wire logic        bwsOpen,
	input  wire logic        ratePin,
	input  wire logic        decodeFault,
	input  wire logic        seqMismatch,
	input  wire logic [19:0] rxBits,
	input  wire logic        rxDe,
	input  wire logic        ctlThreeNormal,
	input  wire logic        pixelTick,
	input  wire logic        oscTick,
	output logic      [17:0] pixelOut,
	output logic             hsOut,
	output logic             vsOut,
	output logic             deOut,
	output logic             ctlThreeOut,
	output logic             faultOut,
	output logic             gpiForward,
	output logic             gpio1Out,
	output logic             gpio0Out,
	output logic             seqKind,
	output logic             autoPixelCount,
	output logic             reverseRateFast,
	output logic             mclkOut,
	output logic             rateSelect,
	output logic             driveBoost,
	output logic             remoteWakeOff,
	output logic             interruptPin
);
	if (FILTER_LEN < 1 || FILTER_LEN > 15) begin : gBadLen
		$error("FILTER_LEN must lie in 1..15");
	end
	if (AUDIO_VIDEO_INFO_BYTES_FIRST > AUDIO_VIDEO_INFO_BYTES_LAST) begin : gBadRange
		$error("AUDIO_VIDEO_INFO_BYTES_FIRST above AUDIO_VIDEO_INFO_BYTES_LAST");
	end

	// ----------------------------------------------------------------
	// Pin synchronisers and strap capture
	// ----------------------------------------------------------------
	logic [PIN_COUNT-1:0] sync1_q;
	logic [PIN_COUNT-1:0] sync2_q;
	logic                 ratePrev_q;
	logic [1:0]           strapCnt_q;
	logic [1:0]           strapCnt_d;
	logic                 strapDone_q;
	logic                 strapNow;

	// Straps are caught once sync2 holds real pin levels after release.
	always_comb begin
		strapCnt_d = strapCnt_q;
		strapNow   = 1'b0;
		if (!strapDone_q) begin
			strapNow   = strapCnt_q == STRAP_WAIT;
			strapCnt_d = strapCnt_q + 2'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_q     <= '0;
			sync2_q     <= '0;
			ratePrev_q  <= 1'b0;
			strapCnt_q  <= 2'h0;
			strapDone_q <= 1'b0;
		end else begin
			sync1_q     <= {ratePin, bwsOpen, gpio0Pin, gpio1Pin, gpiPin};
			sync2_q     <= sync1_q;
			ratePrev_q  <= sync2_q[PIN_RATE];
			strapCnt_q  <= strapCnt_d;
			strapDone_q <= strapDone_q | strapNow;
		end
	end

	// ----------------------------------------------------------------
	// Writable registers
	// ----------------------------------------------------------------
	logic [7:0] testGpio_q, testGpio_d;
	logic [7:0] syncFilt_q, syncFilt_d;
	logic [7:0] syncOut_q, syncOut_d;
	logic [7:0] limit_q, limit_d;
	logic [7:0] reverse_q, reverse_d;
	logic [7:0] audio_q, audio_d;
	logic [7:0] polarity_q, polarity_d;
	logic [7:0] tracking_q, tracking_d;
	logic       rateEdge;

	// Each write merges only the implemented bits; reserved bits stay fixed.
	always_comb begin
		testGpio_d = testGpio_q;
		syncFilt_d = syncFilt_q;
		syncOut_d  = syncOut_q;
		limit_d    = limit_q;
		reverse_d  = reverse_q;
		audio_d    = audio_q;
		polarity_d = polarity_q;
		tracking_d = tracking_q;
		rateEdge   = strapDone_q && (sync2_q[PIN_RATE] != ratePrev_q);
		if (regWrEn) begin
			unique case (regAddr)
				OFS_TEST_GPIO:     testGpio_d = regWrData & MASK_TEST_GPIO; // [RQ1] [RQ3] [RQ17]
				OFS_SYNC_FILTER:   syncFilt_d = regWrData & MASK_SYNC_FILT; // [RQ4] [RQ5]
				OFS_SYNC_OUT:      syncOut_d  = regWrData & MASK_SYNC_OUT;  // [RQ6] [RQ7]
				OFS_FAULT_LIMIT:   limit_d    = regWrData;                  // [RQ8]
				OFS_REVERSE_RATE:  reverse_d  = regWrData & MASK_REVERSE;   // [RQ11]
				OFS_AUDIO_CLOCK:   audio_d    = regWrData;                  // [RQ12] [RQ13]
				OFS_POLARITY_RATE: polarity_d = regWrData & MASK_POLARITY;  // [RQ15] [RQ16]
				OFS_TRACKING:      tracking_d = regWrData & MASK_TRACKING;  // [RQ18]
				default: ;
			endcase
		end
		// Straps load the filter disables and the rate bit once after reset.
		if (strapNow) begin
			syncFilt_d[BIT_DE_FILT:0] = {3{sync2_q[PIN_BWS]}};              // [RQ5]
			polarity_d[BIT_RATE]      = sync2_q[PIN_RATE];                  // [RQ14]
		end
		// A later transition on the rate pin overrides whatever was written.
		if (rateEdge) begin
			polarity_d[BIT_RATE] = sync2_q[PIN_RATE];                       // [RQ14]
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			testGpio_q <= RST_TEST_GPIO;
			syncFilt_q <= RST_ZERO;
			syncOut_q  <= RST_ZERO;
			limit_q    <= RST_ZERO;
			reverse_q  <= RST_ZERO;
			audio_q    <= RST_ZERO;
			polarity_q <= RST_ZERO;
			tracking_q <= RST_TRACKING;
		end else begin
			testGpio_q <= testGpio_d;
			syncFilt_q <= syncFilt_d;
			syncOut_q  <= syncOut_d;
			limit_q    <= limit_d;
			reverse_q  <= reverse_d;
			audio_q    <= audio_d;
			polarity_q <= polarity_d;
			tracking_q <= tracking_d;
		end
	end

	// ----------------------------------------------------------------
	// Fault counters, auto clear, read port and interrupt pin
	// ----------------------------------------------------------------
	logic [7:0]           faultCnt_q, faultCnt_d;
	logic [7:0]           mismatch_q, mismatch_d;
	logic                 faultOut_q, faultOut_d;
	clrState_t            clrState_q, clrState_d;
	logic [CLR_CNT_W-1:0] clrCnt_q, clrCnt_d;
	logic [7:0]           rdData_q, rdData_d;
	logic                 intPin_q, intPin_d;
	logic                 clearNow;
	logic                 avinfoHit;

	// The counters saturate; an event in the clearing cycle still counts.
	always_comb begin
		faultCnt_d = faultCnt_q;
		mismatch_d = mismatch_q;
		clrState_d = clrState_q;
		clrCnt_d   = clrCnt_q;
		clearNow   = 1'b0;
		unique case (clrState_q)
			CLR_IDLE: begin
				if (faultOut_q && testGpio_q[BIT_AUTO_CLEAR]) begin
					clrState_d = CLR_WAIT;
					clrCnt_d   = CLR_CNT_W'(1);
				end
			end
			CLR_WAIT: begin
				clrCnt_d = clrCnt_q + CLR_CNT_W'(1);
				if (!testGpio_q[BIT_AUTO_CLEAR]) begin
					clrState_d = CLR_IDLE;
				end else if (clrCnt_q == CLR_CNT_W'(AUTO_CLEAR_CYC - 1)) begin
					clearNow   = 1'b1;                                     // [RQ2]
					clrState_d = CLR_IDLE;
				end
			end
		endcase
		if (clearNow) begin
			faultCnt_d = RST_ZERO;                                         // [RQ2]
		end
		if (decodeFault && faultCnt_d != COUNT_MAX) begin
			faultCnt_d = faultCnt_d + 8'h01;                               // [RQ9]
		end
		if (seqMismatch && mismatch_q != COUNT_MAX) begin
			mismatch_d = mismatch_q + 8'h01;                               // [RQ10]
		end
		faultOut_d = faultCnt_q > limit_q;                                 // [RQ8]
	end

	// Reads answer one cycle later; unmapped offsets read as zero.
	always_comb begin
		rdData_d  = rdData_q;
		avinfoHit = regAddr >= AUDIO_VIDEO_INFO_BYTES_FIRST && regAddr <= AUDIO_VIDEO_INFO_BYTES_LAST;
		if (regRdEn) begin
			unique case (regAddr)
				OFS_TEST_GPIO:     rdData_d = testGpio_q
					| {3'h0, sync2_q[PIN_GPI], 1'b0, sync2_q[PIN_GENERAL_PIN_ONE],
					1'b0, sync2_q[PIN_GENERAL_PIN_ZERO]};                             // [RQ17]
				OFS_RSVD_SEVEN:    rdData_d = FIX_SEVEN;
				OFS_SYNC_FILTER:   rdData_d = syncFilt_q | FIX_SYNC_FILT;
				OFS_SYNC_OUT:      rdData_d = syncOut_q;
				OFS_RSVD_TEN:      rdData_d = FIX_TEN;
				OFS_RSVD_ELEVEN:   rdData_d = FIX_ELEVEN;
				OFS_FAULT_LIMIT:   rdData_d = limit_q;
				OFS_FAULT_COUNT:   rdData_d = faultCnt_q;                  // [RQ9]
				OFS_MISMATCH:      rdData_d = mismatch_q;                  // [RQ10]
				OFS_REVERSE_RATE:  rdData_d = reverse_q | FIX_REVERSE;
				OFS_AUDIO_CLOCK:   rdData_d = audio_q;
				OFS_POLARITY_RATE: rdData_d = polarity_q;
				OFS_TRACKING:      rdData_d = tracking_q;
				default:           rdData_d = RST_ZERO;
			endcase
		end
		// In auto mode the info-byte traffic drives the pin; else the bit does.
		intPin_d = polarity_q[BIT_INT_OUT];                                // [RQ16]
		if (tracking_q[BIT_AUTO_INT]) begin
			intPin_d = intPin_q;
			if (regWrEn && avinfoHit) begin
				intPin_d = 1'b1;                                           // [RQ18]
			end else if (regRdEn && avinfoHit) begin
				intPin_d = 1'b0;                                           // [RQ18]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			faultCnt_q <= RST_ZERO;
			mismatch_q <= RST_ZERO;
			faultOut_q <= 1'b0;
			clrState_q <= CLR_IDLE;
			clrCnt_q   <= '0;
			rdData_q   <= RST_ZERO;
			intPin_q   <= 1'b0;
		end else begin
			faultCnt_q <= faultCnt_d;
			mismatch_q <= mismatch_d;
			faultOut_q <= faultOut_d;
			clrState_q <= clrState_d;
			clrCnt_q   <= clrCnt_d;
			rdData_q   <= rdData_d;
			intPin_q   <= intPin_d;
		end
	end

	// ----------------------------------------------------------------
	// Video path, audio clock divider and pin outputs
	// ----------------------------------------------------------------
	logic [2:0]  rawSync;
	logic [2:0]  filtSync;
	logic [17:0] pixel_q, pixel_d;
	logic [2:0]  syncOut3_q, syncOut3_d;
	logic        ctlThree_q, ctlThree_d;
	logic        gpiFwd_q, gpiFwd_d;
	logic [6:0]  mclkCnt_q, mclkCnt_d;
	logic        mclk_q, mclk_d;
	logic        srcTick;

	// Filters trade a few cycles of sync latency for glitch immunity.
	for (genvar i = 0; i < 3; i++) begin : gFilt
		deser_glitch_filter #(
			.LEN (FILTER_LEN)
		) uFilt (
			.clk    (clk),
			.rst_b  (rst_b),
			.bypass (syncFilt_q[i]),                                       // [RQ5]
			.din    (rawSync[i]),
			.dout   (filtSync[i])
		);
	end

	// Order of rawSync and filtSync: DE, VS, HS from high to low.
	always_comb begin
		rawSync = {rxDe, rxBits[19], rxBits[18]};
		pixel_d = rxBits[17:0];
		if (syncFilt_q[BIT_SRC_HI]) begin
			rawSync = {rxDe, rxBits[1], rxBits[0]};                        // [RQ4]
			pixel_d = rxBits[19:2];                                        // [RQ4]
		end else if (syncFilt_q[BIT_SRC_HI:BIT_SRC_LO] == SRC_MIDDLE) begin
			rawSync = {rxDe, rxBits[15], rxBits[14]};                      // [RQ4]
		end
		syncOut3_d = filtSync ^ {polarity_q[BIT_INV_DE], polarity_q[BIT_INV_VS],
			polarity_q[BIT_INV_HS]};                                       // [RQ16]
		ctlThree_d = syncOut_q[BIT_VS_PIN] ? syncOut3_d[1] : ctlThreeNormal; // [RQ6]
		gpiFwd_d   = sync2_q[PIN_GPI] & ~testGpio_q[BIT_FWD_OFF];          // [RQ3]
		// The clock toggles every divider ticks of the chosen source.
		srcTick   = audio_q[BIT_MCLK_SRC] ? oscTick : pixelTick;           // [RQ12]
		mclkCnt_d = mclkCnt_q;
		mclk_d    = mclk_q;
		if (audio_q[BIT_DIV_HI:0] == 7'h00) begin
			mclkCnt_d = 7'h00;                                             // [RQ13]
			mclk_d    = 1'b0;
		end else if (srcTick) begin
			if (mclkCnt_q + 7'h01 >= audio_q[BIT_DIV_HI:0]) begin
				mclkCnt_d = 7'h00;
				mclk_d    = ~mclk_q;                                       // [RQ13]
			end else begin
				mclkCnt_d = mclkCnt_q + 7'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pixel_q    <= '0;
			syncOut3_q <= 3'h0;
			ctlThree_q <= 1'b0;
			gpiFwd_q   <= 1'b0;
			mclkCnt_q  <= 7'h00;
			mclk_q     <= 1'b0;
		end else begin
			pixel_q    <= pixel_d;
			syncOut3_q <= syncOut3_d;
			ctlThree_q <= ctlThree_d;
			gpiFwd_q   <= gpiFwd_d;
			mclkCnt_q  <= mclkCnt_d;
			mclk_q     <= mclk_d;
		end
	end

	assign regRdData       = rdData_q;
	assign pixelOut        = pixel_q;
	assign {deOut, vsOut, hsOut} = syncOut3_q;
	assign ctlThreeOut     = ctlThree_q;
	assign faultOut        = faultOut_q;
	assign gpiForward      = gpiFwd_q;
	assign gpio1Out        = testGpio_q[BIT_GENERAL_PIN_ONE_OUT];                    // [RQ17]
	assign gpio0Out        = testGpio_q[BIT_GENERAL_PIN_ZERO_OUT];                    // [RQ17]
	assign seqKind         = testGpio_q[BIT_SEQ_KIND];                     // [RQ1]
	assign autoPixelCount  = syncOut_q[BIT_AUTO_PIX];                      // [RQ7]
	assign reverseRateFast = reverse_q[BIT_REV_FAST];                      // [RQ11]
	assign mclkOut         = mclk_q;
	assign rateSelect      = polarity_q[BIT_RATE];
	assign driveBoost      = polarity_q[BIT_BOOST];                        // [RQ15]
	assign remoteWakeOff   = polarity_q[BIT_WAKE_OFF];                     // [RQ16]
	assign interruptPin    = intPin_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence sClearDue;
		clrState_q == CLR_WAIT && testGpio_q[BIT_AUTO_CLEAR]
			&& clrCnt_q == CLR_CNT_W'(AUTO_CLEAR_CYC - 1);
	endsequence
	sequence sFaultStart;
		clrState_q == CLR_IDLE && faultOut_q && testGpio_q[BIT_AUTO_CLEAR];
	endsequence

	AST_SEQ_KIND: assert property (regWrEn && regAddr == OFS_TEST_GPIO // [RQ1]
		|=> seqKind == $past(regWrData[BIT_SEQ_KIND]))
		else $error("sequence kind bit not stored");
	AST_AUTO_CLEAR: assert property (sClearDue ##0 !decodeFault // [RQ2]
		|=> faultCnt_q == 8'h00)
		else $error("fault count not cleared after wait");
	AST_CLEAR_START: assert property (sFaultStart // [RQ2]
		|=> clrState_q == CLR_WAIT && clrCnt_q == CLR_CNT_W'(1))
		else $error("auto clear wait not started");
	AST_FWD_OFF: assert property (testGpio_q[BIT_FWD_OFF] |=> !gpiForward) // [RQ3]
		else $error("input forwarded while disabled");
	AST_SRC_SHIFT: assert property (syncFilt_q[BIT_SRC_HI] // [RQ4]
		|=> pixelOut == $past(rxBits[19:2]))
		else $error("data not shifted for low sync source");
	AST_VS_PIN: assert property (syncOut_q[BIT_VS_PIN] // [RQ6]
		|=> ctlThreeOut == vsOut)
		else $error("control output three does not carry vsync");
	AST_LIMIT: assert property (regWrEn && regAddr == OFS_FAULT_LIMIT // [RQ8]
		|=> limit_q == $past(regWrData) ##1 faultOut == ($past(faultCnt_q) > $past(limit_q)))
		else $error("fault limit not applied");
	AST_FAULT_CNT: assert property (decodeFault && !clearNow // [RQ9]
		&& faultCnt_q != COUNT_MAX |=> faultCnt_q == $past(faultCnt_q) + 8'h01)
		else $error("decode fault not counted");
	AST_MISMATCH: assert property (seqMismatch && mismatch_q != COUNT_MAX // [RQ10]
		|=> mismatch_q == $past(mismatch_q) + 8'h01)
		else $error("mismatch not counted");
	AST_RATE_PIN: assert property (rateEdge |=> rateSelect == $past(sync2_q[PIN_RATE])) // [RQ14]
		else $error("rate pin transition not applied");
	AST_AUTO_INT: assert property (tracking_q[BIT_AUTO_INT] && regWrEn // [RQ18]
		&& avinfoHit |=> interruptPin)
		else $error("info write did not raise interrupt");
endmodule // deser_config_status_regs

// file: hw/deser_glitch_filter.sv
// Glitch filter for one sync or data-enable line, with a bypass.
module deser_glitch_filter #(
	parameter int LEN = 3
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic bypass,
	input  wire logic din,
	output logic      dout
);
	logic [3:0] cnt_q;
	logic [3:0] cnt_d;
	logic       dout_q;
	logic       dout_d;

	// Unless bypassed, a new level is taken only after it has held LEN cycles.
	always_comb begin
		cnt_d  = 4'h0;
		dout_d = dout_q;
		if (bypass || din == dout_q) begin
			dout_d = din;
		end else if (cnt_q == 4'(LEN - 1)) begin
			dout_d = din;
		end else begin
			cnt_d = cnt_q + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_q  <= 4'h0;
			dout_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			dout_q <= dout_d;
		end
	end

	assign dout = dout_q;
endmodule // deser_glitch_filter

// file: hw/deser_regs_pkg.sv
// Register offsets, field positions, reset values and timing for the deserializer register bank.
package deser_regs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_TEST_GPIO     = 8'h06;
	localparam logic [7:0] OFS_RSVD_SEVEN    = 8'h07;
	localparam logic [7:0] OFS_SYNC_FILTER   = 8'h08;
	localparam logic [7:0] OFS_SYNC_OUT      = 8'h09;
	localparam logic [7:0] OFS_RSVD_TEN      = 8'h0A;
	localparam logic [7:0] OFS_RSVD_ELEVEN   = 8'h0B;
	localparam logic [7:0] OFS_FAULT_LIMIT   = 8'h0C;
	localparam logic [7:0] OFS_FAULT_COUNT   = 8'h0D;
	localparam logic [7:0] OFS_MISMATCH      = 8'h0E;
	localparam logic [7:0] OFS_REVERSE_RATE  = 8'h11;
	localparam logic [7:0] OFS_AUDIO_CLOCK   = 8'h12;
	localparam logic [7:0] OFS_RSVD_NINETEEN = 8'h13;
	localparam logic [7:0] OFS_POLARITY_RATE = 8'h14;
	localparam logic [7:0] OFS_TRACKING      = 8'h15;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_SEQ_KIND   = 7;
	localparam int BIT_AUTO_CLEAR = 6;
	localparam int BIT_FWD_OFF    = 5;
	localparam int BIT_GPI_IN     = 4;
	localparam int BIT_GENERAL_PIN_ONE_OUT  = 3;
	localparam int BIT_GENERAL_PIN_ONE_IN   = 2;
	localparam int BIT_GENERAL_PIN_ZERO_OUT  = 1;
	localparam int BIT_GENERAL_PIN_ZERO_IN   = 0;
	localparam int BIT_SRC_HI     = 4;
	localparam int BIT_SRC_LO     = 3;
	localparam int BIT_DE_FILT    = 2;
	localparam int BIT_VS_PIN     = 7;
	localparam int BIT_AUTO_PIX   = 6;
	localparam int BIT_REV_FAST   = 7;
	localparam int BIT_MCLK_SRC   = 7;
	localparam int BIT_DIV_HI     = 6;
	localparam int BIT_INV_VS     = 7;
	localparam int BIT_INV_HS     = 6;
	localparam int BIT_INV_DE     = 5;
	localparam int BIT_RATE       = 4;
	localparam int BIT_BOOST      = 3;
	localparam int BIT_WAKE_OFF   = 2;
	localparam int BIT_INT_OUT    = 0;
	localparam int BIT_AUTO_INT   = 7;

	// ----------------------------------------------------------------
	// Writable masks, reset values and fixed reserved read values
	// ----------------------------------------------------------------
	localparam logic [7:0] MASK_TEST_GPIO = 8'hEA;
	localparam logic [7:0] MASK_SYNC_FILT = 8'h1F;
	localparam logic [7:0] MASK_SYNC_OUT  = 8'hC0;
	localparam logic [7:0] MASK_REVERSE   = 8'h80;
	localparam logic [7:0] MASK_POLARITY  = 8'hFD;
	localparam logic [7:0] MASK_TRACKING  = 8'h80;
	localparam logic [7:0] RST_TEST_GPIO  = 8'h0A;
	localparam logic [7:0] RST_ZERO       = 8'h00;
	localparam logic [7:0] RST_TRACKING   = 8'h80;
	localparam logic [7:0] FIX_SEVEN      = 8'h54;
	localparam logic [7:0] FIX_SYNC_FILT  = 8'h20;
	localparam logic [7:0] FIX_TEN        = 8'h10;
	localparam logic [7:0] FIX_ELEVEN     = 8'h20;
	localparam logic [7:0] FIX_REVERSE    = 8'h22;
	localparam logic [7:0] COUNT_MAX      = 8'hFF;

	// Sync source codes; any code with the upper bit set selects bits 0/1.
	localparam logic [1:0] SRC_UPPER  = 2'h0;
	localparam logic [1:0] SRC_MIDDLE = 2'h1;

	// Synchronised pin slots.
	localparam int PIN_GPI   = 0;
	localparam int PIN_GENERAL_PIN_ONE = 1;
	localparam int PIN_GENERAL_PIN_ZERO = 2;
	localparam int PIN_BWS   = 3;
	localparam int PIN_RATE  = 4;
	localparam int PIN_COUNT = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 4;
	localparam int AUTO_CLEAR_NS  = 1000;
	localparam int AUTO_CLEAR_CYC = (AUTO_CLEAR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CLR_CNT_W      = $clog2(AUTO_CLEAR_CYC + 1);
	localparam logic [1:0] STRAP_WAIT = 2'h2;
	localparam int FILTER_LEN_DEF = 3;
	localparam logic [7:0] AUDIO_VIDEO_INFO_BYTES_FIRST_DEF = 8'h60;
	localparam logic [7:0] AUDIO_VIDEO_INFO_BYTES_LAST_DEF  = 8'h7F;

	typedef enum logic {
		CLR_IDLE = 1'b0,
		CLR_WAIT = 1'b1
	} clrState_t;

endpackage

// file: test/deser_host_model.sv
// Host model that issues single-byte writes and reads on the register port.
module deser_host_model (
	input  wire logic       clk,
	output logic      [7:0] regAddr,
	output logic            regWrEn,
	output logic      [7:0] regWrData,
	output logic            regRdEn,
	input  wire logic [7:0] regRdData
);
	timeunit 1ns;
	timeprecision 1ps;

	// The port rests idle from time zero.
	initial begin
		regAddr = 8'h00;
		regWrEn = 1'b0;
		regWrData = 8'h00;
		regRdEn = 1'b0;
	end

	// One write; the strobe is held for exactly the edge that takes it.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge clk);
		regWrEn <= 1'b0;
		#1;
	endtask

	// One read; data lands on the edge after the strobe, so it is taken once that edge settles.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge clk);
		regRdEn <= 1'b0;
		#1;
		d = regRdData;
	endtask
endmodule // deser_host_model

// file: test/tb_top.sv
// Self-checking bench for the deserializer register bank.
module tb_top import deser_regs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0, rst_b = 1'b0, gpiPin = 1'b0, gpio1Pin = 1'b0, gpio0Pin = 1'b0;
	logic        bwsOpen = 1'b0, ratePin = 1'b0, decodeFault = 1'b0, seqMismatch = 1'b0;
	logic        rxDe = 1'b0, ctlThreeNormal = 1'b0, pixelTick = 1'b0, oscTick = 1'b0, m0;
	logic [19:0] rxBits = 20'h00000;
	logic [7:0]  regAddr, regWrData, regRdData, rv;
	logic [17:0] pixelOut;
	logic        regWrEn, regRdEn, hsOut, vsOut, deOut, ctlThreeOut, faultOut, gpiForward;
	logic        gpio1Out, gpio0Out, seqKind, autoPixelCount, reverseRateFast, mclkOut;
	logic        rateSelect, driveBoost, remoteWakeOff, interruptPin;
	int          num_errors = 0, checks_done = 0;

	// Free-running 250 MHz clock.
	initial forever #2 clk = ~clk;

	deser_config_status_regs DUT (.*);
	deser_host_model host (.*);

	// ----------------------------------------------------------------
	// Shared checking and closing
	// ----------------------------------------------------------------
	task automatic chk(input logic [17:0] g, input logic [17:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		host.rd(a, rv);
		chk({10'h000, rv}, {10'h000, e});
	endtask
	// Lets a fixed number of edges pass and samples off the edge.
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_values();
		rc(OFS_TEST_GPIO, 8'h0A);
		rc(OFS_RSVD_SEVEN, 8'h54);
		rc(OFS_SYNC_FILTER, 8'h20);
		rc(OFS_SYNC_OUT, 8'h00);
		rc(OFS_FAULT_LIMIT, 8'h00);
		rc(OFS_MISMATCH, 8'h00);
		rc(OFS_REVERSE_RATE, 8'h22);
		rc(OFS_AUDIO_CLOCK, 8'h00);
		rc(OFS_POLARITY_RATE, 8'h00);
		rc(8'h30, 8'h00);
		host.wr(OFS_FAULT_LIMIT, 8'hA5);
		rc(OFS_FAULT_LIMIT, 8'hA5);
		host.wr(OFS_RSVD_SEVEN, 8'h00);
		rc(OFS_RSVD_SEVEN, 8'h54);
		host.wr(OFS_FAULT_COUNT, 8'h33);
		rc(OFS_FAULT_COUNT, 8'h00);
		// Both link ends are assumed to run the fast reverse rate from here on.
		host.wr(OFS_REVERSE_RATE, 8'h80);
		rc(OFS_REVERSE_RATE, 8'hA2);
		host.wr(OFS_POLARITY_RATE, 8'h1E);
		host.wr(OFS_SYNC_OUT, 8'h40);
		settle(2);
		chk({rateSelect, driveBoost, remoteWakeOff, autoPixelCount, reverseRateFast}, 5'h1F);
		rc(OFS_POLARITY_RATE, 8'h1C);
		gpiPin <= 1'b1;
		gpio1Pin <= 1'b1;
		host.wr(OFS_TEST_GPIO, 8'hE0);
		settle(4);
		chk({seqKind, gpiForward, gpio1Out, gpio0Out}, 4'h8);
		rc(OFS_TEST_GPIO, 8'hF4);
		host.wr(OFS_TEST_GPIO, 8'h0A);
		settle(2);
		chk({gpiForward, gpio1Out, gpio0Out}, 3'h7);
		$display("register values done");
	endtask

	task automatic t_counters();
		host.wr(OFS_FAULT_LIMIT, 8'h01);
		decodeFault <= 1'b1;
		seqMismatch <= 1'b1;
		repeat (2) @(posedge clk);
		seqMismatch <= 1'b0;
		@(posedge clk);
		decodeFault <= 1'b0;
		rc(OFS_FAULT_COUNT, 8'h03);
		rc(OFS_FAULT_COUNT, 8'h03);
		rc(OFS_MISMATCH, 8'h02);
		chk(faultOut, 1'b1);
		host.wr(OFS_TEST_GPIO, 8'h4A);
		settle(200);
		rc(OFS_FAULT_COUNT, 8'h03);
		settle(60);
		rc(OFS_FAULT_COUNT, 8'h00);
		host.wr(OFS_TEST_GPIO, 8'h0A);
		$display("counters done");
	endtask

	task automatic t_video();
		rxBits <= 20'hABCDE;
		host.wr(OFS_SYNC_FILTER, 8'h10);
		settle(3);
		chk(pixelOut, 18'h2AF37);
		host.wr(OFS_SYNC_FILTER, 8'h07);
		settle(3);
		chk(pixelOut, 18'h2BCDE);
		rxBits <= 20'h80000;
		rxDe <= 1'b1;
		settle(5);
		chk({deOut, vsOut, hsOut}, 3'h6);
		ctlThreeNormal <= 1'b1;
		settle(2);
		chk(ctlThreeOut, 1'b1);
		host.wr(OFS_SYNC_FILTER, 8'h0F);
		host.wr(OFS_SYNC_OUT, 8'h80);
		settle(5);
		chk({vsOut, ctlThreeOut}, 2'h0);
		host.wr(OFS_POLARITY_RATE, 8'h80);
		settle(5);
		chk({vsOut, ctlThreeOut}, 2'h3);
		$display("video done");
	endtask

	task automatic t_misc();
		host.wr(AUDIO_VIDEO_INFO_BYTES_FIRST_DEF, 8'h00);
		settle(2);
		chk(interruptPin, 1'b1);
		host.rd(AUDIO_VIDEO_INFO_BYTES_FIRST_DEF, rv);
		settle(2);
		chk(interruptPin, 1'b0);
		host.wr(OFS_TRACKING, 8'h00);
		host.wr(OFS_POLARITY_RATE, 8'h01);
		settle(2);
		chk(interruptPin, 1'b1);
		host.wr(OFS_AUDIO_CLOCK, 8'h82);
		oscTick <= 1'b1;
		settle(4);
		m0 = mclkOut;
		settle(2);
		chk(mclkOut, {~m0});
		// Pixel source selected while only the oscillator ticks: the clock must stall.
		host.wr(OFS_AUDIO_CLOCK, 8'h02);
		settle(1);
		m0 = mclkOut;
		settle(4);
		chk(mclkOut, {m0});
		pixelTick <= 1'b1;
		settle(3);
		m0 = mclkOut;
		settle(2);
		chk(mclkOut, {~m0});
		host.wr(OFS_AUDIO_CLOCK, 8'h00);
		settle(4);
		chk(mclkOut, 1'b0);
		$display("interrupt and audio clock done");
	endtask

	// A second reset with the width pin open and the rate pin high reloads the straps.
	task automatic t_strap();
		@(posedge clk);
		rst_b <= 1'b0;
		bwsOpen <= 1'b1;
		ratePin <= 1'b1;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		settle(4);
		chk({gpio1Out, gpio0Out, interruptPin}, 3'h6);
		rc(OFS_SYNC_FILTER, 8'h27);
		rc(OFS_POLARITY_RATE, 8'h10);
		ratePin <= 1'b0;
		settle(5);
		chk(rateSelect, 1'b0);
		$display("strap reload done");
	endtask

	// Main sequence: reset for 16 cycles, wait out the strap capture, then run.
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		t_values();
		t_counters();
		t_video();
		t_misc();
		t_strap();
		results();
	end

	// Watchdog well beyond the few hundred cycles the scenarios need.
	initial begin
		#40000;
		num_errors++;
		results();
	end
endmodule // tb_top
